// ### sais_pkg.sv
// Package: register map, field layout, reset values and strap tables for strap/image select
package sais_pkg;
	localparam logic [7:0] REG_SLAVE_ADDRESS_BASE = 8'h40;
	localparam logic [7:0] REG_ADDRESS_OPTION_CONTROL = 8'h42;
	localparam logic [7:0] REG_FILTER_ZERO_DEFAULTS_B = 8'h62;
	localparam logic [7:0] REG_FILTER_ZERO_DEFAULTS_A = 8'h64;
	localparam logic [7:0] REG_LOAD_STATUS = 8'h66;
	localparam int PMB_ADDR_LSB = 0;
	localparam int I2C_ADDR_LSB = 8;
	localparam int OFFSET_DISABLE_BIT = 6;
	localparam int FZ0_LSB = 12;
	localparam int FZ1_LSB = 0;
	localparam int FZ2_LSB = 4;
	localparam int FZ3_LSB = 8;
	localparam int FZ4_LSB = 12;
	localparam logic [15:0] SLAVE_ADDRESS_BASE_RST = 16'h1010;
	localparam logic [15:0] ADDRESS_OPTION_CONTROL_RST = 16'h0000;
	// Codes are capacitance minus 1 pF: 1,2,4,6,8 pF
	localparam logic [15:0] FILTER_ZERO_DEFAULTS_B_RST = 16'h7531;
	localparam logic [15:0] FILTER_ZERO_DEFAULTS_A_RST = 16'h0000;
	localparam int MAX_IMAGE_SLOT = 12;
	localparam int IMAGE_COUNT = 14;
	localparam int USER_IMAGE_COUNT = 13;
	localparam int SETTLE_CYCLES = 16;
	// Overcurrent class per current-limit strap class (index 0 = short)
	localparam logic [3:0] OCL_TABLE [16] = '{4'h1, 4'h7, 4'h2, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
		4'h5, 4'h6, 4'h3, 4'h7, 4'h5, 4'h6, 4'h0, 4'h4};
	// Filter-zero code (0..4) per current-limit strap class
	localparam logic [2:0] FZ_TABLE [16] = '{3'h0, 3'h4, 3'h2, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2,
		3'h3, 3'h4, 3'h1, 3'h3, 3'h2, 3'h3, 3'h1, 3'h3};
	typedef enum logic [3:0] {
		ST_SETTLE = 4'h1,
		ST_CAPTURE = 4'h2,
		ST_CHECK = 4'h4,
		ST_RUN = 4'h8
	} sais_state_t;
endpackage : sais_pkg

// ### sais_sync.sv
// Two-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
`default_nettype none
module sais_sync #(
	parameter int WIDTH = 4
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta <= '0;
			q_o <= '0;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule // sais_sync
`default_nettype wire

// ### sais_top.sv
// Strap decode, address and configuration image selection at power-up
// Contract
// - Current-limit strap class picks overcurrent limit through fixed lookup at power-up.
// - Same strap picks default filter-zero code, independent of overcurrent limit.
// - Host field 0x64[14:12] sets capacitance 1..8 pF, overriding strap default.
// - Five filter-zero code defaults held in rewritable 3-bit register fields.
// - Address/image strap classes 0..15 give slave offset for both interfaces.
// - Store holds 14 images, one factory, at most 13 user images.
// - Multi-image store loads slot equal to offset 0..12; 13..15 unsupported.
// - Usable offset range 0..12 multi-image, 0..15 single-image.
// - Single-image store loads most recent image regardless of strap offset.
// - Offset-disable bit set makes base fields the effective addresses.
// - Offset-disable clear: effective address is base plus strap offset.
// - I2C base in upper byte bits 14:8, PMBus base in bits 6:0.
// - PMBus base address zero disables the PMBus interface.
// - CRC checked every power-up; failure blocks regulation start.
`timescale 1ns/1ps
`default_nettype none
module sais_top
	import sais_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [3:0] current_limit_strap_i,
	input wire logic [3:0] address_image_strap_i,
	input wire logic multi_image_i,
	input wire logic [3:0] last_image_i,
	input wire logic crc_ok_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	output logic [3:0] overcurrent_limit_o,
	output logic [2:0] loop_filter_zero_o,
	output logic [6:0] i2c_addr_o,
	output logic [6:0] pmbus_addr_o,
	output logic pmbus_en_o,
	output logic [3:0] image_slot_o,
	output logic image_valid_o,
	output logic load_done_o,
	output logic regulate_en_o
);
	logic [3:0] current_limit_strap_s;
	logic [3:0] addr_s;
	logic [1:0] flags_s;
	logic [3:0] last_s;
	sais_state_t state;
	logic [4:0] settle_cnt;
	logic [3:0] current_limit_strap_cls;
	logic [3:0] addr_off;
	logic [15:0] slave_address_base;
	logic [15:0] address_option_control;
	logic [15:0] filter_zero_defaults_b;
	logic [15:0] filter_zero_defaults_a;
	logic fz_override;
	logic [2:0] fz_code;
	logic [2:0] next_fz;
	logic [6:0] next_i2c;
	logic [6:0] next_pmb;
	logic off_dis;

	sais_sync #(.WIDTH(4)) u_sync_current_limit_strap (
		.clk_i(clk_i), .nrst_i(nrst_i), .d_i(current_limit_strap_i), .q_o(current_limit_strap_s)
	);
	sais_sync #(.WIDTH(4)) u_sync_addr (
		.clk_i(clk_i), .nrst_i(nrst_i), .d_i(address_image_strap_i), .q_o(addr_s)
	);
	sais_sync #(.WIDTH(2)) u_sync_flags (
		.clk_i(clk_i), .nrst_i(nrst_i), .d_i({multi_image_i, crc_ok_i}), .q_o(flags_s)
	);
	// Store pointer comes from outside this clock, so it is synchronised too
	sais_sync #(.WIDTH(4)) u_sync_last (
		.clk_i(clk_i), .nrst_i(nrst_i), .d_i(last_image_i), .q_o(last_s)
	);

	// Power-up sequencer: let straps settle, capture once, check, run
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= ST_SETTLE;
			settle_cnt <= '0;
		end else begin
			case (state)
				ST_SETTLE: begin
					if (settle_cnt == 5'(SETTLE_CYCLES - 1)) begin
						state <= ST_CAPTURE;
					end else begin
						settle_cnt <= settle_cnt + 5'h01;
					end
				end
				ST_CAPTURE: state <= ST_CHECK;
				ST_CHECK: state <= ST_RUN;
				ST_RUN: state <= ST_RUN;
				default: state <= ST_SETTLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			current_limit_strap_cls <= 4'h0;
			addr_off <= 4'h0;
			overcurrent_limit_o <= 4'h0;
			fz_code <= 3'h0;
		end else if (state == ST_CAPTURE) begin
			current_limit_strap_cls <= current_limit_strap_s;
			addr_off <= addr_s;
			overcurrent_limit_o <= OCL_TABLE[current_limit_strap_s];
			fz_code <= FZ_TABLE[current_limit_strap_s];
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			image_slot_o <= 4'h0;
			image_valid_o <= 1'b0;
		end else if (state == ST_CHECK) begin
			if (flags_s[1]) begin
				image_slot_o <= addr_off;
				image_valid_o <= (addr_off <= 4'(MAX_IMAGE_SLOT));
			end else begin
				image_slot_o <= last_s;
				image_valid_o <= (last_s < 4'(IMAGE_COUNT));
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			load_done_o <= 1'b0;
			regulate_en_o <= 1'b0;
		end else if (state == ST_CHECK) begin
			load_done_o <= 1'b1;
			regulate_en_o <= flags_s[0];
		end
	end

	// Host register file; straps are never re-read here
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			slave_address_base <= SLAVE_ADDRESS_BASE_RST;
			address_option_control <= ADDRESS_OPTION_CONTROL_RST;
			filter_zero_defaults_b <= FILTER_ZERO_DEFAULTS_B_RST;
			filter_zero_defaults_a <= FILTER_ZERO_DEFAULTS_A_RST;
			fz_override <= 1'b0;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				REG_SLAVE_ADDRESS_BASE: slave_address_base <= reg_wdata_i & 16'h7f7f;
				REG_ADDRESS_OPTION_CONTROL: address_option_control <= reg_wdata_i;
				REG_FILTER_ZERO_DEFAULTS_B: filter_zero_defaults_b <= reg_wdata_i & 16'h7777;
				REG_FILTER_ZERO_DEFAULTS_A: begin
					filter_zero_defaults_a <= reg_wdata_i;
					fz_override <= 1'b1;
				end
				default: fz_override <= fz_override;
			endcase
		end
	end

	always_comb begin
		if (fz_override) begin
			next_fz = filter_zero_defaults_a[FZ0_LSB +: 3];
		end else begin
			case (fz_code)
				3'h0: next_fz = filter_zero_defaults_a[FZ0_LSB +: 3];
				3'h1: next_fz = filter_zero_defaults_b[FZ1_LSB +: 3];
				3'h2: next_fz = filter_zero_defaults_b[FZ2_LSB +: 3];
				3'h3: next_fz = filter_zero_defaults_b[FZ3_LSB +: 3];
				3'h4: next_fz = filter_zero_defaults_b[FZ4_LSB +: 3];
				default: next_fz = filter_zero_defaults_a[FZ0_LSB +: 3];
			endcase
		end
	end

	assign off_dis = address_option_control[OFFSET_DISABLE_BIT];

	always_comb begin
		if (off_dis) begin
			next_i2c = slave_address_base[I2C_ADDR_LSB +: 7];
			next_pmb = slave_address_base[PMB_ADDR_LSB +: 7];
		end else begin
			next_i2c = slave_address_base[I2C_ADDR_LSB +: 7] + {3'h0, addr_off};
			next_pmb = slave_address_base[PMB_ADDR_LSB +: 7] + {3'h0, addr_off};
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			loop_filter_zero_o <= 3'h0;
			i2c_addr_o <= 7'h00;
			pmbus_addr_o <= 7'h00;
			pmbus_en_o <= 1'b0;
		end else if (load_done_o) begin
			loop_filter_zero_o <= next_fz;
			i2c_addr_o <= next_i2c;
			pmbus_addr_o <= next_pmb;
			pmbus_en_o <= (slave_address_base[PMB_ADDR_LSB +: 7] != 7'h00);
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reg_rdata_o <= 16'h0000;
		end else begin
			case (reg_addr_i)
				REG_SLAVE_ADDRESS_BASE: reg_rdata_o <= slave_address_base;
				REG_ADDRESS_OPTION_CONTROL: reg_rdata_o <= address_option_control;
				REG_FILTER_ZERO_DEFAULTS_B: reg_rdata_o <= filter_zero_defaults_b;
				REG_FILTER_ZERO_DEFAULTS_A: reg_rdata_o <= filter_zero_defaults_a;
				REG_LOAD_STATUS: reg_rdata_o <= {current_limit_strap_cls, addr_off, image_slot_o,
					image_valid_o, regulate_en_o, load_done_o, fz_override};
				default: reg_rdata_o <= 16'h0000;
			endcase
		end
	end
endmodule // sais_top
`default_nettype wire

// ### sais_properties.sv
// Checker for strap decode, address and image selection
`timescale 1ns/1ps
`default_nettype none
module sais_properties
	import sais_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic multi_image_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic [3:0] overcurrent_limit_o,
	input wire logic [2:0] loop_filter_zero_o,
	input wire logic pmbus_en_o,
	input wire logic [3:0] image_slot_o,
	input wire logic image_valid_o,
	input wire logic load_done_o,
	input wire logic regulate_en_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	sequence s_wr(logic [7:0] a);
		load_done_o && reg_wr_i && reg_addr_i == a;
	endsequence
	property p_reg_gate; regulate_en_o |-> load_done_o; endproperty
	a_reg_gate: assert property (p_reg_gate) else $error("regulating before load");
	property p_crc_hold; load_done_o && !regulate_en_o |=> !regulate_en_o; endproperty
	a_crc_hold: assert property (p_crc_hold) else $error("start after bad check");
	property p_done_hold; load_done_o |=> load_done_o; endproperty
	a_done_hold: assert property (p_done_hold) else $error("load done dropped");
	property p_ocl_hold; $past(load_done_o) |-> $stable(overcurrent_limit_o); endproperty
	a_ocl_hold: assert property (p_ocl_hold) else $error("limit changed after load");
	property p_img_range; image_valid_o && multi_image_i |-> image_slot_o <= 4'hc; endproperty
	a_img_range: assert property (p_img_range) else $error("image slot above 12");
	property p_pmb_off;
		s_wr(REG_SLAVE_ADDRESS_BASE) ##0 reg_wdata_i[6:0] == 7'h00 |-> ##2 !pmbus_en_o;
	endproperty
	a_pmb_off: assert property (p_pmb_off) else $error("pmbus on with zero base");
	property p_fz_ovr;
		s_wr(REG_FILTER_ZERO_DEFAULTS_A) |-> ##2 loop_filter_zero_o == $past(reg_wdata_i[14:12], 2);
	endproperty
	a_fz_ovr: assert property (p_fz_ovr) else $error("filter zero not overridden");
	property p_rsv; reg_addr_i == REG_SLAVE_ADDRESS_BASE |=> !reg_rdata_o[15] && !reg_rdata_o[7]; endproperty
	a_rsv: assert property (p_rsv) else $error("address reserved bits set");
endmodule // sais_properties
bind sais_top sais_properties sais_properties_inst (.clk_i, .nrst_i, .multi_image_i, .reg_wr_i,
	.reg_addr_i, .reg_wdata_i, .reg_rdata_o, .overcurrent_limit_o, .loop_filter_zero_o,
	.pmbus_en_o, .image_slot_o, .image_valid_o, .load_done_o, .regulate_en_o);
`default_nettype wire

// ### sais_strap_model.sv
// Strap resistors and configuration store as seen from the pins
`timescale 1ns/1ps
`default_nettype none
module sais_strap_model (
	input wire logic [3:0] current_limit_strap_cls_i,
	input wire logic [3:0] addr_cls_i,
	input wire logic [3:0] user_images_i,
	output logic [3:0] current_limit_strap_o,
	output logic [3:0] address_image_strap_o,
	output logic [3:0] last_image_o
);
	assign current_limit_strap_o = current_limit_strap_cls_i;
	assign address_image_strap_o = addr_cls_i;
	// factory image in slot 0, at most 13 user images after it
	assign last_image_o = (user_images_i > 4'hd) ? 4'hd : user_images_i;
endmodule // sais_strap_model
`default_nettype wire

// ### tb.sv
// Self-checking bench for strap decode and image select
`timescale 1ns/1ps
`default_nettype none
module tb
	import sais_pkg::*;
;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [3:0] current_limit_strap_i, address_image_strap_i, last_image_i;
	logic multi_image_i = 1'b0;
	logic crc_ok_i = 1'b1;
	logic reg_wr_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic [15:0] reg_rdata_o;
	logic [3:0] overcurrent_limit_o, image_slot_o, current_limit_strap, acls, uimg;
	logic [2:0] loop_filter_zero_o;
	logic [6:0] i2c_addr_o, pmbus_addr_o;
	logic pmbus_en_o, image_valid_o, load_done_o, regulate_en_o, v;
	logic [27:0] e;
	logic [3:0] t_c [4] = '{4'h8, 4'hf, 4'h0, 4'h1};
	logic [3:0] t_a [4] = '{4'hd, 4'h3, 4'hf, 4'h5};
	logic [3:0] t_u [4] = '{4'h0, 4'h9, 4'h2, 4'h0};
	logic [3:0] t_m = 4'b1001;
	logic [3:0] t_k = 4'b1011;
	int n_fail = 0;
	int compares = 0;
	always #20 clk_i = ~clk_i;
	sais_strap_model sais_strap_model_inst (.current_limit_strap_cls_i(current_limit_strap), .addr_cls_i(acls),
		.user_images_i(uimg), .current_limit_strap_o(current_limit_strap_i),
		.address_image_strap_o(address_image_strap_i), .last_image_o(last_image_i));
	sais_top sais_top_inst (.clk_i, .nrst_i, .current_limit_strap_i, .address_image_strap_i,
		.multi_image_i, .last_image_i, .crc_ok_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
		.reg_rdata_o, .overcurrent_limit_o, .loop_filter_zero_o, .i2c_addr_o, .pmbus_addr_o,
		.pmbus_en_o, .image_slot_o, .image_valid_o, .load_done_o, .regulate_en_o);
	task automatic check(input logic [27:0] seen, input logic [27:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic write(input logic [7:0] a, input logic [15:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		tick(1);
		reg_wr_i = 1'b0;
		tick(2);
	endtask
	task automatic read(input logic [7:0] a, input logic [15:0] exp);
		reg_addr_i = a;
		tick(1);
		check({12'h000, reg_rdata_o}, {12'h000, exp});
	endtask
	// Straps only count at power-up, so every strap case needs a full reset
	task automatic power_up(input int n);
		nrst_i = 1'b0;
		current_limit_strap = t_c[n];
		acls = t_a[n];
		uimg = t_u[n];
		multi_image_i = t_m[n];
		crc_ok_i = t_k[n];
		tick(12);
		nrst_i = 1'b1;
		for (int i = 0; i < 60 && load_done_o !== 1'b1; i++)
			tick(1);
		if (load_done_o !== 1'b1) begin
			n_fail++;
			give_verdict();
		end
		// Derived outputs follow one cycle after load done
		tick(1);
	endtask
	function automatic logic [2:0] fz(input logic [2:0] k);
		return (k == 3'h0) ? FILTER_ZERO_DEFAULTS_A_RST[14:12]
			: FILTER_ZERO_DEFAULTS_B_RST[4*(k-1) +: 3];
	endfunction
	function automatic logic [27:0] outs();
		return {overcurrent_limit_o, loop_filter_zero_o, i2c_addr_o, pmbus_addr_o, pmbus_en_o,
			image_valid_o ? image_slot_o : 4'h0, image_valid_o, regulate_en_o};
	endfunction
	initial begin
		for (int n = 0; n < 4; n++) begin
			power_up(n);
			v = t_m[n] ? (t_a[n] <= 4'hc) : 1'b1;
			e = {OCL_TABLE[t_c[n]], fz(FZ_TABLE[t_c[n]]),
				SLAVE_ADDRESS_BASE_RST[14:8] + {3'h0, t_a[n]},
				SLAVE_ADDRESS_BASE_RST[6:0] + {3'h0, t_a[n]}, 1'b1,
				v ? (t_m[n] ? t_a[n] : t_u[n]) : 4'h0, v, t_k[n]};
			check(outs(), e);
		end
		current_limit_strap = 4'h3;
		acls = 4'h7;
		tick(8);
		check(outs(), e);
		write(REG_SLAVE_ADDRESS_BASE, 16'h2000);
		check({20'h0, i2c_addr_o, pmbus_en_o}, {20'h0, 7'h25, 1'b0});
		read(REG_SLAVE_ADDRESS_BASE, 16'h2000);
		write(REG_SLAVE_ADDRESS_BASE, 16'hffff);
		read(REG_SLAVE_ADDRESS_BASE, 16'h7f7f);
		check({13'h0, i2c_addr_o, pmbus_addr_o, pmbus_en_o}, {13'h0, 7'h04, 7'h04, 1'b1});
		write(REG_ADDRESS_OPTION_CONTROL, 16'h0040);
		check({14'h0, i2c_addr_o, pmbus_addr_o}, {14'h0, 7'h7f, 7'h7f});
		write(REG_FILTER_ZERO_DEFAULTS_A, 16'h5000);
		check({21'h0, overcurrent_limit_o, loop_filter_zero_o}, {21'h0, OCL_TABLE[1], 3'h5});
		read(REG_FILTER_ZERO_DEFAULTS_A, 16'h5000);
		write(REG_FILTER_ZERO_DEFAULTS_B, 16'hffff);
		read(REG_FILTER_ZERO_DEFAULTS_B, 16'h7777);
		read(8'h44, 16'h0000);
		read(REG_LOAD_STATUS, 16'h155f);
		give_verdict();
	end
endmodule // tb
`default_nettype wire
